// File: ssh_pkg.sv
package ssh_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned HOLD_TIMEOUT_MS = 2048;
  localparam int unsigned PS_WAIT_MS     = 200;
  localparam int unsigned PULSE_SHORT_US = 100;
  localparam int unsigned PULSE_LONG_US  = 1000;
  localparam int unsigned HOLD_TIMEOUT_CYC = HOLD_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned PS_WAIT_CYC    = PS_WAIT_MS * CLK_MHZ * 1000;
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_US * CLK_MHZ;
  localparam int unsigned PULSE_LONG_CYC = PULSE_LONG_US * CLK_MHZ;

  localparam logic [11:0] OFS_SESSION = 12'h038;
  localparam logic [11:0] OFS_CONFIG  = 12'h03C;
  localparam logic [11:0] OFS_EVENT   = 12'h040;
  localparam logic [11:0] OFS_STATUS  = 12'h044;

  localparam int unsigned HOLD_BIT      = 2;
  localparam int unsigned ACK_BIT       = 7;
  localparam int unsigned POL_BIT       = 5;
  localparam int unsigned LEN_BIT       = 4;
  localparam int unsigned FLAGS_W       = 4;
  localparam int unsigned FRAME_BITS    = 16;
  localparam logic [2:0]  PIN_FUNC_PS   = 3'h5;
  localparam logic [2:0]  SESSION_RST   = 3'h0;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;

  typedef enum {
    ST_IDLE, ST_READY, ST_HOLD, ST_SPI_ON, ST_PS_WAIT, ST_ATTN, ST_RELEASE
  } ssh_state_e;

  typedef struct packed {
    logic       polarity;
    logic       pulseLong;
    logic [2:0] pinFunc;
  } ssh_cfg_s;

  typedef struct packed {
    logic csN;
    logic sclk;
  } ssh_pins_s;

endpackage

// File: ssh_sync.sv
`timescale 1ns/1ps
module ssh_sync #(
  parameter int unsigned    W       = 2,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         rst,      // Synchronous reset.
  input  wire logic         ce,       // Clock enable.
  input  wire logic [W-1:0] d,        // Asynchronous inputs.
  output logic      [W-1:0] q         // Synchronised outputs.
);

  logic [W-1:0] stage1_r;

  generate
    if (W < 1) begin : g_chk
      $error("ssh_sync width must be at least one");
    end
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stage1_r[i] <= RST_VAL[i];
          q[i]        <= RST_VAL[i];
        end else if (ce) begin
          stage1_r[i] <= d[i];
          q[i]        <= stage1_r[i];
        end
      end
    end
  endgenerate

endmodule

// File: ssh_session.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ssh_session #(
  parameter int unsigned TIMEOUT_CYC = ssh_pkg::HOLD_TIMEOUT_CYC,
  parameter int unsigned PS_WAIT_CYC = ssh_pkg::PS_WAIT_CYC,
  parameter int unsigned PULSE_S_CYC = ssh_pkg::PULSE_SHORT_CYC,
  parameter int unsigned PULSE_L_CYC = ssh_pkg::PULSE_LONG_CYC
) (
  input  wire logic        clk_sys,       // System clock, 200 MHz.
  input  wire logic        rst,           // Synchronous reset.
  input  wire logic        ce,            // Clock enable.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire logic        csWakeN,       // Select / wake pin.
  input  wire logic        sclk,          // Serial clock pin.
  input  wire logic [3:0]  eventIn,       // Event sources.
  input  wire logic        hostHoldClr,   // Host serial hold clear.
  input  wire logic        hostAckCmd,    // Host serial ack command.
  output logic             readyAttn,     // Ready / attention pin.
  output logic             powerSwitch,   // Power switch enable pin.
  output logic             spiEnable,     // Serial port enable.
  output logic             cpuHold,       // Core hold.
  output logic             frameValid,    // Frame may be served.
  output logic             cmdRun,        // Execute host commands.
  output logic             cmdSkip        // Host commands dropped.
);

  //////////////////////////////////////////////////////////////////////////
  // Parameter checks and pin synchronisers.

  generate
    if (TIMEOUT_CYC < 1 || PS_WAIT_CYC < 1 || PULSE_S_CYC < 1 ||
        PULSE_L_CYC < 1) begin : g_chk
      $error("ssh_session cycle counts must be at least one");
    end
  endgenerate

  ssh_pkg::ssh_pins_s pinSync;
  ssh_pkg::ssh_pins_s pinPrev_r;

  ssh_sync #(
    .W       (2),
    .RST_VAL (2'b10)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d       ({csWakeN, sclk}),
    .q       (pinSync)
  );

  logic csFall;
  logic csRise;
  logic sclkRise;

  assign csFall   = pinPrev_r.csN & ~pinSync.csN;
  assign csRise   = ~pinPrev_r.csN & pinSync.csN;
  assign sclkRise = ~pinPrev_r.sclk & pinSync.sclk;

  //////////////////////////////////////////////////////////////////////////
  // Register state.

  ssh_pkg::ssh_cfg_s      cfg_r, cfg_nxt;
  logic [1:0]             range_r, range_nxt;
  logic [3:0]             flags_r, flags_nxt;
  logic                   ackPend_r, ackPend_nxt;
  logic                   clkFault_r, clkFault_nxt;
  logic                   contend_r, contend_nxt;
  logic                   frameBad_r, frameBad_nxt;
  logic [4:0]             edgeCnt_r, edgeCnt_nxt;
  logic                   frameValid_nxt;
  logic [31:0]            prdata_nxt;
  logic                   pready_nxt;
  logic                   pslverr_nxt;
  ssh_pkg::ssh_state_e    state_r, state_nxt;
  logic [31:0]            cnt_r, cnt_nxt;
  logic                   hostSess_r, hostSess_nxt;
  logic                   active_r, active_nxt;
  logic                   powerSwitch_nxt;
  logic                   spiEnable_nxt;
  logic                   cpuHold_nxt;
  logic                   cmdRun_nxt;
  logic                   cmdSkip_nxt;
  logic                   readyAttn_nxt;

  logic                   apbWr;
  logic                   apbRd;
  logic                   swHoldSet;
  logic                   swHoldClr;
  logic                   hostClear;
  logic                   attnBusy;

  assign apbWr    = psel & penable & pwrite & pready;
  assign apbRd    = psel & ~penable & ~pwrite;
  assign attnBusy = (state_r == ssh_pkg::ST_ATTN);

  assign swHoldSet = apbWr && paddr == ssh_pkg::OFS_SESSION &&
                     pwdata[ssh_pkg::HOLD_BIT];
  assign swHoldClr = apbWr && paddr == ssh_pkg::OFS_SESSION &&
                     !pwdata[ssh_pkg::HOLD_BIT];
  assign hostClear = (hostHoldClr || swHoldClr) && cpuHold;

  //////////////////////////////////////////////////////////////////////////
  // APB slave and software-visible registers.

  always_comb begin
    cfg_nxt     = cfg_r;
    range_nxt   = range_r;
    ackPend_nxt = ackPend_r;
    flags_nxt   = flags_r;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        ssh_pkg::OFS_SESSION: begin
          prdata_nxt[ssh_pkg::HOLD_BIT:0] = {cpuHold, range_r};
        end
        ssh_pkg::OFS_CONFIG: begin
          prdata_nxt[ssh_pkg::POL_BIT:0] = {cfg_r.polarity,
                                            cfg_r.pulseLong, 1'b0,
                                            cfg_r.pinFunc};
        end
        ssh_pkg::OFS_EVENT: begin
          prdata_nxt[ssh_pkg::ACK_BIT] = ackPend_r;
          prdata_nxt[3:0]              = flags_r;
        end
        ssh_pkg::OFS_STATUS: begin
          prdata_nxt[7:0] = {hostSess_r, active_r, spiEnable,
                             contend_r, clkFault_r, powerSwitch,
                             readyAttn, cpuHold};
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
      if (!apbRd) begin
        prdata_nxt = 32'h0000_0000;
      end
    end
    if (apbWr) begin
      case (paddr)
        ssh_pkg::OFS_SESSION: begin
          range_nxt = pwdata[1:0];
        end
        ssh_pkg::OFS_CONFIG: begin
          cfg_nxt.polarity  = pwdata[ssh_pkg::POL_BIT];
          cfg_nxt.pulseLong = pwdata[ssh_pkg::LEN_BIT];
          cfg_nxt.pinFunc   = pwdata[2:0];
        end
        ssh_pkg::OFS_EVENT: begin
          if (pwdata[ssh_pkg::ACK_BIT]) begin
            ackPend_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (hostAckCmd) begin
      ackPend_nxt = 1'b1;
    end
    // Flags are cleared only when an acknowledged session ends properly.
    if (hostClear && ackPend_r) begin
      flags_nxt   = 4'h0;
      ackPend_nxt = 1'b0;
    end
    if (!active_r && state_r == ssh_pkg::ST_IDLE) begin
      ackPend_nxt = 1'b0;
    end
    flags_nxt = flags_nxt | eventIn;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r     <= ssh_pkg::CONFIG_RST[4:0];
      range_r   <= ssh_pkg::SESSION_RST[1:0];
      ackPend_r <= 1'b0;
      flags_r   <= 4'h0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else if (ce) begin
      cfg_r     <= cfg_nxt;
      range_r   <= range_nxt;
      ackPend_r <= ackPend_nxt;
      flags_r   <= flags_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial frame watcher: clock faults and contention.

  always_comb begin
    edgeCnt_nxt    = edgeCnt_r;
    clkFault_nxt   = clkFault_r;
    contend_nxt    = contend_r;
    frameBad_nxt   = frameBad_r;
    frameValid_nxt = 1'b0;
    if (csFall) begin
      edgeCnt_nxt  = 5'h00;
      frameBad_nxt = attnBusy;
      if (attnBusy) begin
        contend_nxt = 1'b1;
      end else begin
        contend_nxt = 1'b0;
      end
    end else if (!pinSync.csN && sclkRise && edgeCnt_r != 5'h1F) begin
      edgeCnt_nxt = edgeCnt_r + 5'h01;
    end
    if (csRise) begin
      if (edgeCnt_r == 5'h00) begin
        clkFault_nxt = 1'b1;
      end else if (clkFault_r) begin
        if (edgeCnt_r == 5'(ssh_pkg::FRAME_BITS)) begin
          clkFault_nxt = 1'b0;
        end
      end else if (edgeCnt_r == 5'(ssh_pkg::FRAME_BITS) && !frameBad_r &&
                   spiEnable && cpuHold) begin
        frameValid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinPrev_r  <= 2'b10;
      edgeCnt_r  <= 5'h00;
      clkFault_r <= 1'b0;
      contend_r  <= 1'b0;
      frameBad_r <= 1'b0;
      frameValid <= 1'b0;
    end else if (ce) begin
      pinPrev_r  <= pinSync;
      edgeCnt_r  <= edgeCnt_nxt;
      clkFault_r <= clkFault_nxt;
      contend_r  <= contend_nxt;
      frameBad_r <= frameBad_nxt;
      frameValid <= frameValid_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Session sequencer.

  always_comb begin
    state_nxt       = state_r;
    cnt_nxt         = cnt_r;
    hostSess_nxt    = hostSess_r;
    active_nxt      = active_r;
    powerSwitch_nxt = powerSwitch;
    spiEnable_nxt   = spiEnable;
    cpuHold_nxt     = cpuHold;
    cmdRun_nxt      = 1'b0;
    cmdSkip_nxt     = 1'b0;
    case (state_r)
      ssh_pkg::ST_IDLE: begin
        active_nxt = 1'b0;
        if (csFall) begin
          spiEnable_nxt = 1'b1;
          active_nxt    = 1'b1;
          hostSess_nxt  = 1'b1;
          state_nxt     = ssh_pkg::ST_READY;
        end else if (flags_r != 4'h0) begin
          spiEnable_nxt = 1'b1;
          hostSess_nxt  = 1'b0;
          state_nxt     = ssh_pkg::ST_SPI_ON;
        end else if (cpuHold) begin
          state_nxt     = ssh_pkg::ST_HOLD;
        end
      end
      ssh_pkg::ST_READY: begin
        active_nxt  = 1'b1;
        cpuHold_nxt = 1'b1;
        cnt_nxt     = 32'h0000_0000;
        state_nxt   = ssh_pkg::ST_HOLD;
      end
      ssh_pkg::ST_SPI_ON: begin
        cnt_nxt = 32'h0000_0000;
        if (cfg_r.pinFunc == ssh_pkg::PIN_FUNC_PS) begin
          powerSwitch_nxt = 1'b1;
          state_nxt       = ssh_pkg::ST_PS_WAIT;
        end else begin
          state_nxt = ssh_pkg::ST_ATTN;
        end
      end
      ssh_pkg::ST_PS_WAIT: begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (cnt_r == PS_WAIT_CYC - 1) begin
          cnt_nxt   = 32'h0000_0000;
          state_nxt = ssh_pkg::ST_ATTN;
        end
      end
      ssh_pkg::ST_ATTN: begin
        active_nxt = 1'b1;
        cnt_nxt    = cnt_r + 32'h0000_0001;
        if (cnt_r == (cfg_r.pulseLong ? PULSE_L_CYC : PULSE_S_CYC)) begin
          active_nxt  = 1'b0;
          cpuHold_nxt = 1'b1;
          cnt_nxt     = 32'h0000_0000;
          state_nxt   = ssh_pkg::ST_HOLD;
        end
      end
      ssh_pkg::ST_HOLD: begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (hostClear) begin
          cpuHold_nxt = 1'b0;
          active_nxt  = 1'b0;
          cmdRun_nxt  = 1'b1;
          state_nxt   = ssh_pkg::ST_RELEASE;
        end else if (!cpuHold || cnt_r == TIMEOUT_CYC - 1) begin
          cpuHold_nxt = 1'b0;
          active_nxt  = 1'b0;
          cmdSkip_nxt = 1'b1;
          state_nxt   = ssh_pkg::ST_RELEASE;
        end
      end
      ssh_pkg::ST_RELEASE: begin
        spiEnable_nxt   = 1'b0;
        powerSwitch_nxt = 1'b0;
        cnt_nxt         = 32'h0000_0000;
        state_nxt       = ssh_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ssh_pkg::ST_IDLE;
      end
    endcase
    if (swHoldSet && state_r != ssh_pkg::ST_RELEASE) begin
      cpuHold_nxt = 1'b1;
    end
    readyAttn_nxt = active_nxt ~^ cfg_r.polarity;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r     <= ssh_pkg::ST_IDLE;
      cnt_r       <= 32'h0000_0000;
      hostSess_r  <= 1'b0;
      active_r    <= 1'b0;
      powerSwitch <= 1'b0;
      spiEnable   <= 1'b0;
      cpuHold     <= 1'b0;
      cmdRun      <= 1'b0;
      cmdSkip     <= 1'b0;
      readyAttn   <= 1'b1;
    end else if (ce) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      hostSess_r  <= hostSess_nxt;
      active_r    <= active_nxt;
      powerSwitch <= powerSwitch_nxt;
      spiEnable   <= spiEnable_nxt;
      cpuHold     <= cpuHold_nxt;
      cmdRun      <= cmdRun_nxt;
      cmdSkip     <= cmdSkip_nxt;
      readyAttn   <= readyAttn_nxt;
    end
  end

endmodule

// File: ssh_session_sva.sv
`timescale 1ns/1ps
module ssh_session_sva #(
  parameter int unsigned TIMEOUT_CYC = 200,
  parameter int unsigned PS_WAIT_CYC = 50
) (
  input wire logic        clk_sys,      // Clock.
  input wire logic        rst,          // Reset.
  input wire logic        psel,         // Select.
  input wire logic        penable,      // Enable.
  input wire logic        pwrite,       // Direction.
  input wire logic [11:0] paddr,        // Address.
  input wire logic [31:0] pwdata,       // Write data.
  input wire logic        pready,       // Ready.
  input wire logic        readyAttn,    // Ready pin.
  input wire logic        powerSwitch,  // Switch pin.
  input wire logic        spiEnable,    // Port on.
  input wire logic        cpuHold,      // Hold bit.
  input wire logic        frameValid,   // Frame served.
  input wire logic        cmdRun,       // Clear exit.
  input wire logic        cmdSkip       // Timeout exit.
);
  localparam int TLO = TIMEOUT_CYC - 1;
  localparam int THI = TIMEOUT_CYC + 1;
  localparam int PLO = PS_WAIT_CYC - 2;
  localparam int PHI = PS_WAIT_CYC + 3;
  logic pol_r;
  logic pol_nxt;
  int   hold_r;
  int   hold_nxt;
  logic attnAct;
  //////////////////////////////////////////////////////////////////////////
  // Tracks the configured pin polarity and how long the hold has stood.
  always_comb begin
    pol_nxt  = pol_r;
    hold_nxt = cpuHold ? hold_r + 1 : 0;
    if (psel && penable && pready && pwrite
        && paddr == ssh_pkg::OFS_CONFIG) begin
      pol_nxt = pwdata[ssh_pkg::POL_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pol_r  <= 1'b0;
      hold_r <= 0;
    end else begin
      pol_r  <= pol_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign attnAct = (readyAttn == pol_r);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  attn_needs_port_a: assert property (
    $rose(attnAct) && $past(pol_r, 2) == pol_r |-> spiEnable)
    else $error("Pin went active with the serial port off.");
  idle_level_a: assert property (
    !spiEnable && !$past(spiEnable) && $past(pol_r, 2) == pol_r
    |-> !attnAct) else $error("Pin not idle while port is off.");
  hold_cause_a: assert property (
    $rose(cpuHold) |-> $past(attnAct) && spiEnable)
    else $error("Hold set without a preceding pin indication.");
  host_release_a: assert property (
    cmdRun |-> !cpuHold && !attnAct && spiEnable ##1 !spiEnable)
    else $error("Wrong order on session release.");
  timeout_exit_a: assert property (
    cmdSkip |-> !cmdRun && !cpuHold && hold_r >= TLO
    ##1 !spiEnable && !powerSwitch)
    else $error("Timeout exit wrong.");
  hold_limit_a: assert property (
    cpuHold |-> hold_r <= THI) else $error("Hold outlived the timeout.");
  ps_wait_a: assert property (
    $rose(powerSwitch) |-> ##[PLO:PHI] $rose(attnAct))
    else $error("Pulse not after the power switch wait.");
  frame_gate_a: assert property (
    frameValid |-> cpuHold && spiEnable ##1 !frameValid)
    else $error("Frame served outside a held session.");
  bus_answer_a: assert property (
    psel && !penable |=> pready) else $error("Bus access not answered.");
endmodule

bind ssh_session ssh_session_sva #(
  .TIMEOUT_CYC(TIMEOUT_CYC),
  .PS_WAIT_CYC(PS_WAIT_CYC)
) i_ssh_session_sva (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .readyAttn(readyAttn), .powerSwitch(powerSwitch),
  .spiEnable(spiEnable), .cpuHold(cpuHold), .frameValid(frameValid),
  .cmdRun(cmdRun), .cmdSkip(cmdSkip)
);

// File: ssh_host_model.sv
`timescale 1ns/1ps
module ssh_host_model (
  output logic csWakeN,  // Select / wake line.
  output logic sclk      // Serial clock, still outside frames.
);
  localparam realtime HALF = 24.0;
  initial begin
    csWakeN = 1'b1;
    sclk    = 1'b0;
  end
  task wake;
    csWakeN = 1'b0;
  endtask
  // Select handed back to the port block before any clock runs.
  task endWake;
    csWakeN = 1'b1;
  endtask
  task frame(input int bits);
    csWakeN = 1'b0;
    #(HALF);
    repeat (bits) begin
      sclk = 1'b1;
      #(HALF);
      sclk = 1'b0;
      #(HALF);
    end
    csWakeN = 1'b1;
    #(4 * HALF);
  endtask
endmodule

// File: ssh_session_bench.sv
`timescale 1ns/1ps
module ssh_session_bench;
  logic        clk_sys, rst, ce, psel, penable, pwrite, pslverr, pready;
  logic        csWakeN, sclk, hostHoldClr, hostAckCmd, err, pol;
  logic        readyAttn, powerSwitch, spiEnable, cpuHold;
  logic        frameValid, cmdRun, cmdSkip;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  eventIn;
  int          fail_count = 0;
  int          comparisons = 0;
  int          fvCount = 0;
  int          runCount = 0;
  int          runLen = 0;
  int          lastLen = 0;
  int          n, v;
  wire         attn = (readyAttn === pol);
  localparam int TO_CYC = 1000, PS_CYC = 50, PLS_S = 10, PLS_L = 20;

  ssh_session #(
    .TIMEOUT_CYC(TO_CYC), .PS_WAIT_CYC(PS_CYC), .PULSE_S_CYC(PLS_S),
    .PULSE_L_CYC(PLS_L)
  ) i_ssh_session (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .csWakeN(csWakeN), .sclk(sclk), .eventIn(eventIn),
    .hostHoldClr(hostHoldClr), .hostAckCmd(hostAckCmd),
    .readyAttn(readyAttn), .powerSwitch(powerSwitch),
    .spiEnable(spiEnable), .cpuHold(cpuHold), .frameValid(frameValid),
    .cmdRun(cmdRun), .cmdSkip(cmdSkip)
  );
  ssh_host_model i_ssh_host_model (.csWakeN(csWakeN), .sclk(sclk));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Counts served frames and clear exits, and measures pin pulses.
  always @(posedge clk_sys) begin
    if (frameValid === 1'b1) fvCount++;
    if (cmdRun === 1'b1) runCount++;
    if (attn) runLen++;
    else if (runLen != 0) begin
      lastLen = runLen;
      runLen  = 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    chk(n, 32'h1);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, hostHoldClr, hostAckCmd, pol} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    eventIn = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // An event seen only while the clock enable is low must be lost.
    ce      <= 1'b0;
    eventIn <= 4'h1;
    @(posedge clk_sys);
    eventIn <= 4'h0;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, spiEnable}, 32'h0);
    apb(0, ssh_pkg::OFS_SESSION, 0);
    chk(rd, 32'h0);
    apb(0, 12'h100, 0);
    chk({rd[30:0], err}, 32'h1);
    chk({31'h0, readyAttn}, 32'h1);
    apb(1, ssh_pkg::OFS_CONFIG, 32'h20);
    pol = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, readyAttn}, 32'h0);
    i_ssh_host_model.wake();
    for (n = 0; n < 60 && !attn; n++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cpuHold}, 32'h1);
    apb(0, ssh_pkg::OFS_SESSION, 0);
    chk(rd, 32'h4);
    i_ssh_host_model.endWake();
    repeat (8) @(posedge clk_sys);
    apb(0, ssh_pkg::OFS_STATUS, 0);
    chk(rd & 32'h8, 32'h8);
    v = fvCount;
    i_ssh_host_model.frame(16);
    repeat (5) @(posedge clk_sys);
    chk(fvCount, v);
    apb(0, ssh_pkg::OFS_STATUS, 0);
    chk(rd & 32'h8, 32'h0);
    i_ssh_host_model.frame(16);
    repeat (5) @(posedge clk_sys);
    chk(fvCount, v + 1);
    v = runCount;
    hostHoldClr <= 1'b1;
    @(posedge clk_sys);
    hostHoldClr <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(runCount, v + 1);
    chk({29'h0, readyAttn, spiEnable, cpuHold}, 32'h0);
    apb(1, ssh_pkg::OFS_CONFIG, 32'h05);
    pol = 1'b0;
    eventIn <= 4'h1;
    @(posedge clk_sys);
    eventIn <= 4'h0;
    for (n = 0; n < 10 && powerSwitch !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, powerSwitch}, 32'h1);
    for (n = 0; n < 200 && cpuHold !== 1'b1; n++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk(lastLen, PLS_S);
    chk({31'h0, spiEnable}, 32'h1);
    apb(1, ssh_pkg::OFS_CONFIG, 32'h10);
    for (n = 0; n < TO_CYC + 200 && cmdSkip !== 1'b1; n++) @(posedge clk_sys);
    chk(runCount, v + 1);
    apb(0, ssh_pkg::OFS_SESSION, 0);
    chk(rd, 32'h0);
    chk({31'h0, powerSwitch}, 32'h0);
    v = fvCount;
    for (n = 0; n < 40 && !attn; n++) @(posedge clk_sys);
    i_ssh_host_model.frame(16);
    repeat (4) @(posedge clk_sys);
    chk(fvCount, v);
    apb(0, ssh_pkg::OFS_STATUS, 0);
    chk(rd & 32'h10, 32'h10);
    chk(lastLen, PLS_L);
    for (n = 0; n < 40 && attn; n++) @(posedge clk_sys);
    i_ssh_host_model.frame(16);
    repeat (5) @(posedge clk_sys);
    chk(fvCount, v + 1);
    apb(0, ssh_pkg::OFS_EVENT, 0);
    chk(rd & 32'hF, 32'h1);
    hostAckCmd <= 1'b1;
    @(posedge clk_sys);
    hostAckCmd <= 1'b0;
    v = runCount;
    apb(1, ssh_pkg::OFS_SESSION, 0);
    repeat (3) @(posedge clk_sys);
    chk(runCount, v + 1);
    apb(0, ssh_pkg::OFS_EVENT, 0);
    chk(rd & 32'hF, 32'h0);
    end_of_test();
  end
endmodule
